/* File: verilog/dssc_pkg.sv */
// package of the single-tone and clock configuration block
// assumes one 125 MHz core clock and a 2-channel synthesizer core behind it
package dssc_pkg;

   // ****************************************
   // register addresses (5-bit serial address)
   // ****************************************
   localparam logic [4:0] ADDR_CHANNEL_SELECT       = 5'h00;
   localparam logic [4:0] ADDR_FUNCTION_CONFIG_ONE  = 5'h01;
   localparam logic [4:0] ADDR_CHANNEL_FUNCTION     = 5'h03;
   localparam logic [4:0] ADDR_FREQUENCY_TUNING     = 5'h04;
   localparam logic [4:0] ADDR_PHASE_OFFSET         = 5'h05;

   // data bytes per register, last byte index
   localparam logic [1:0] LAST_BYTE_ONE   = 2'h0;
   localparam logic [1:0] LAST_BYTE_TWO   = 2'h1;
   localparam logic [1:0] LAST_BYTE_THREE = 2'h2;
   localparam logic [1:0] LAST_BYTE_FOUR  = 2'h3;

   // ****************************************
   // serial instruction byte
   // ****************************************
   localparam int          INSTR_READ_BIT = 7;
   localparam int          INSTR_ADDR_MSB = 4;
   localparam logic [2:0]  LAST_BIT       = 3'h7;

   // ****************************************
   // field layouts and reset values
   // ****************************************
   localparam int          SEL_EN_LSB     = 6;      // channel enables [7:6]
   localparam int          SEL_MODE_MSB   = 2;      // serial mode [2:1]
   localparam int          SEL_MODE_LSB   = 1;
   localparam logic [7:0]  SEL_RST        = 8'hc0;  // both enables set, single-bit mode
   localparam int          CFG1_VCO_BIT   = 23;
   localparam int          CFG1_MULT_MSB  = 22;
   localparam int          CFG1_MULT_LSB  = 18;
   localparam int          CFG1_CP_MSB    = 17;
   localparam int          CFG1_CP_LSB    = 16;
   localparam logic [23:0] CFG1_RST       = 24'h000000; // vco low, bypass, 75 uA
   localparam int          CHFN_MATCH_BIT = 5;
   localparam logic [23:0] CHFN_RST       = 24'h000000;
   localparam logic [31:0] FREQ_RST       = 32'h00000000;
   localparam logic [15:0] PHASE_RST      = 16'h0000;

   // ****************************************
   // clock multiplier decode
   // ****************************************
   localparam logic [4:0]  MULT_MIN       = 5'h04;
   localparam logic [4:0]  MULT_MAX       = 5'h14;
   localparam logic [4:0]  MULT_BYPASS    = 5'h01;
   localparam logic [1:0]  CP_75UA        = 2'h0;

   // sync clock is the system clock divided by four
   localparam logic [1:0]  SYNC_RISE_CNT  = 2'h1;

   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic [31:0] freq;
      logic [15:0] phase;
   } dssc_tone_t;

   typedef struct packed {
      logic       pll_enable;   // multiplier in use
      logic [4:0] mult_factor;  // effective factor, 1 in bypass
      logic       vco_high;     // vco gain range
      logic [1:0] cp_current;   // charge pump setting
      logic       xtal_osc_en;  // crystal oscillator on
      logic       ref_buf_en;   // reference input buffer on
   } dssc_clk_cfg_t;

endpackage

/* File: verilog/dssc_sync.sv */
// two-stage synchroniser for a group of pin inputs
// assumes the inputs are asynchronous to the clock
`timescale 1ns/1ns
module dssc_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta;

   // first stage read only by the second
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         meta     <= '0;
         sync_out <= '0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule

/* File: verilog/dssc_top.sv */
// single-tone configuration and system clock control of a 2-channel synthesizer
// assumes host drives the serial port pins, core_clk is the system clock
`timescale 1ns/1ns
module dssc_top #(
   parameter int NUM_CHAN = 2
) (
   input  wire logic                                core_clk,
   input  wire logic                                sys_rst,
   input  wire logic                                sclk,
   input  wire logic                                cs_n,
   input  wire logic                                sdio_in,
   output logic                                     sdio_out,
   output logic                                     sdio_oe,
   input  wire logic                                io_update,
   input  wire logic                                clk_mode_sel,
   output logic                                     sync_clk,
   output logic                                     single_bit_mode,
   output dssc_pkg::dssc_tone_t [NUM_CHAN-1:0]      tone_out,
   output dssc_pkg::dssc_clk_cfg_t                  clk_cfg
);
   import dssc_pkg::*;

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [4:0] pins_s;
   logic       s_sclk;
   logic       s_csn;
   logic       s_sdi;
   logic       s_ioup;
   logic       s_xsel;

   dssc_sync #(.W(5)) u_sync (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .async_in ({sclk, cs_n, sdio_in, io_update, clk_mode_sel}),
      .sync_out (pins_s)
   );

   assign {s_sclk, s_csn, s_sdi, s_ioup, s_xsel} = pins_s;

   // ****************************************
   // serial port
   // ****************************************
   logic        sclk_q;
   logic        sclk_rise;
   logic        sclk_fall;
   logic [2:0]  bit_cnt;
   logic [1:0]  byte_cnt;
   logic        in_data;
   logic [7:0]  instr;
   logic [31:0] shreg;
   logic [31:0] next_shreg;
   logic [31:0] rd_shift;
   logic [31:0] rd_word;
   logic [1:0]  last_byte;
   logic [4:0]  next_addr;
   logic        wr_stb;
   logic [4:0]  wr_addr;
   logic [31:0] wr_data;
   logic        byte_done;
   logic        is_read;

   assign sclk_rise  = s_sclk & ~sclk_q;
   assign sclk_fall  = ~s_sclk & sclk_q;
   assign next_shreg = {shreg[30:0], s_sdi};
   assign byte_done  = sclk_rise & (bit_cnt == LAST_BIT);
   assign is_read    = instr[INSTR_READ_BIT];
   assign next_addr  = next_shreg[INSTR_ADDR_MSB:0];

   // bytes per register, by address
   function automatic logic [1:0] last_byte_of(input logic [4:0] a);
      case (a)
         ADDR_FUNCTION_CONFIG_ONE: last_byte_of = LAST_BYTE_THREE;
         ADDR_CHANNEL_FUNCTION:    last_byte_of = LAST_BYTE_THREE;
         ADDR_FREQUENCY_TUNING:    last_byte_of = LAST_BYTE_FOUR;
         ADDR_PHASE_OFFSET:        last_byte_of = LAST_BYTE_TWO;
         default:                  last_byte_of = LAST_BYTE_ONE;
      endcase
   endfunction

   assign last_byte = last_byte_of(instr[INSTR_ADDR_MSB:0]);

   // edge tracking of the serial clock
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= s_sclk;
      end
   end

   // bit and byte framing, chip select high restarts
   always_ff @(posedge core_clk) begin
      if (sys_rst || s_csn) begin
         bit_cnt  <= '0;
         byte_cnt <= '0;
         in_data  <= 1'b0;
         shreg    <= '0;
         instr    <= '0;
      end else if (sclk_rise) begin
         shreg   <= next_shreg;
         bit_cnt <= bit_cnt + 3'h1;
         if (byte_done && !in_data) begin
            instr    <= next_shreg[7:0];
            in_data  <= 1'b1;
            byte_cnt <= '0;
            shreg    <= '0;
         end else if (byte_done) begin
            byte_cnt <= (byte_cnt == last_byte) ? 2'h0 : byte_cnt + 2'h1;
         end
      end
   end

   // write strobe after the last data byte of a register
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wr_stb  <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
      end else begin
         wr_stb  <= byte_done & in_data & ~is_read & ~s_csn & (byte_cnt == last_byte);
         wr_addr <= instr[INSTR_ADDR_MSB:0];
         wr_data <= next_shreg;
      end
   end

   // ****************************************
   // configuration registers
   // ****************************************
   logic [7:0]                    channel_select;
   logic [23:0]                   function_config_one;
   logic [NUM_CHAN-1:0][23:0]     channel_function;
   logic [NUM_CHAN-1:0][31:0]     freq_shadow;
   logic [NUM_CHAN-1:0][15:0]     phase_shadow;
   logic [NUM_CHAN-1:0][31:0]     freq_active;
   logic [NUM_CHAN-1:0][15:0]     phase_active;
   logic [NUM_CHAN-1:0]           chan_en;
   logic                          update_evt;

   // enables steer writes straight from the register
   assign chan_en = channel_select[SEL_EN_LSB +: NUM_CHAN];

   // channel select, reset enables all channels
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         channel_select <= SEL_RST;
      end else if (wr_stb && wr_addr == ADDR_CHANNEL_SELECT) begin
         channel_select <= wr_data[7:0];
      end
   end

   // function register one
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         function_config_one <= CFG1_RST;
      end else if (wr_stb && wr_addr == ADDR_FUNCTION_CONFIG_ONE) begin
         function_config_one <= wr_data[23:0];
      end
   end

   // per-channel words through shared addresses
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int c = 0; c < NUM_CHAN; c++) begin
            channel_function[c] <= CHFN_RST;
            freq_shadow[c]      <= FREQ_RST;
            phase_shadow[c]     <= PHASE_RST;
         end
      end else if (wr_stb) begin
         for (int c = 0; c < NUM_CHAN; c++) begin
            if (chan_en[c]) begin
               if (wr_addr == ADDR_CHANNEL_FUNCTION) channel_function[c] <= wr_data[23:0];
               if (wr_addr == ADDR_FREQUENCY_TUNING) freq_shadow[c] <= wr_data;
               if (wr_addr == ADDR_PHASE_OFFSET) phase_shadow[c] <= wr_data[15:0];
            end
         end
      end
   end

   // active words change only on an update
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         freq_active  <= '0;
         phase_active <= '0;
      end else if (update_evt) begin
         freq_active  <= freq_shadow;
         phase_active <= phase_shadow;
      end
   end

   // ****************************************
   // sync clock and update sampling
   // ****************************************
   logic [1:0] div_cnt;
   logic       ioup_smp;

   // divide by four, output straight from a flop
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         div_cnt  <= '0;
         sync_clk <= 1'b0;
      end else begin
         div_cnt  <= div_cnt + 2'h1;
         sync_clk <= div_cnt[1];
      end
   end

   // update rising edge seen one core clock before the sync clock rise
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ioup_smp   <= 1'b0;
         update_evt <= 1'b0;
      end else begin
         update_evt <= 1'b0;
         if (div_cnt == SYNC_RISE_CNT) begin
            ioup_smp   <= s_ioup;
            update_evt <= s_ioup & ~ioup_smp;
         end
      end
   end

   // ****************************************
   // output pipeline
   // ****************************************
   logic [NUM_CHAN-1:0][31:0] freq_d1;
   logic [NUM_CHAN-1:0][31:0] freq_d2;
   logic [NUM_CHAN-1:0][15:0] phase_d1;
   logic [NUM_CHAN-1:0][15:0] phase_d2;

   // phase normally one stage, three when matched
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         freq_d1  <= '0;
         freq_d2  <= '0;
         phase_d1 <= '0;
         phase_d2 <= '0;
         tone_out <= '0;
      end else begin
         freq_d1  <= freq_active;
         freq_d2  <= freq_d1;
         phase_d1 <= phase_active;
         phase_d2 <= phase_d1;
         for (int c = 0; c < NUM_CHAN; c++) begin
            tone_out[c].freq  <= freq_d2[c];
            tone_out[c].phase <= channel_function[c][CHFN_MATCH_BIT] ? phase_d2[c] : phase_active[c];
         end
      end
   end

   // ****************************************
   // clock configuration decode
   // ****************************************
   logic [4:0] mult_field;
   logic       mult_ok;

   assign mult_field = function_config_one[CFG1_MULT_MSB:CFG1_MULT_LSB];
   assign mult_ok    = (mult_field >= MULT_MIN) && (mult_field <= MULT_MAX);

   // multiplier, vco, charge pump and source select
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         clk_cfg         <= '0;
         clk_cfg.mult_factor <= MULT_BYPASS;
         clk_cfg.cp_current  <= CP_75UA;
         clk_cfg.ref_buf_en  <= 1'b1;
         single_bit_mode <= 1'b1;
      end else begin
         clk_cfg.pll_enable  <= mult_ok;
         clk_cfg.mult_factor <= mult_ok ? mult_field : MULT_BYPASS;
         clk_cfg.vco_high    <= function_config_one[CFG1_VCO_BIT];
         clk_cfg.cp_current  <= function_config_one[CFG1_CP_MSB:CFG1_CP_LSB];
         clk_cfg.xtal_osc_en <= s_xsel;
         clk_cfg.ref_buf_en  <= ~s_xsel;
         single_bit_mode <= (channel_select[SEL_MODE_MSB:SEL_MODE_LSB] == 2'h0);
      end
   end

   // ****************************************
   // readback
   // ****************************************
   logic rd_chan;

   // channel 0 answers shared addresses when enabled, else channel 1
   assign rd_chan = chan_en[0] ? 1'b0 : 1'b1;

   always_comb begin
      case (next_addr)
         ADDR_CHANNEL_SELECT:      rd_word = {channel_select, 24'h000000};
         ADDR_FUNCTION_CONFIG_ONE: rd_word = {function_config_one, 8'h00};
         ADDR_CHANNEL_FUNCTION:    rd_word = {channel_function[rd_chan], 8'h00};
         ADDR_FREQUENCY_TUNING:    rd_word = freq_shadow[rd_chan];
         ADDR_PHASE_OFFSET:        rd_word = {phase_shadow[rd_chan], 16'h0000};
         default:                  rd_word = 32'h00000000;
      endcase
   end

   // shift out msb first on serial clock falls
   always_ff @(posedge core_clk) begin
      if (sys_rst || s_csn) begin
         rd_shift <= '0;
         sdio_out <= 1'b0;
         sdio_oe  <= 1'b0;
      end else begin
         if (byte_done && !in_data) begin
            rd_shift <= rd_word;
         end else if (sclk_fall && in_data && is_read) begin
            sdio_out <= rd_shift[31];
            sdio_oe  <= 1'b1;
            rd_shift <= {rd_shift[30:0], 1'b0};
         end
      end
   end

endmodule

/* File: sim/dssc_top_chk.sv */
// checker of the single-tone and clock configuration block
// assumes it is bound to dssc_top and sees only its ports
`timescale 1ns/1ns
module dssc_top_chk
   import dssc_pkg::*;
#(
   parameter int NUM_CHAN = 2
) (
   input wire logic                            core_clk,
   input wire logic                            sys_rst,
   input wire logic                            sclk,
   input wire logic                            cs_n,
   input wire logic                            sdio_in,
   input wire logic                            sdio_out,
   input wire logic                            sdio_oe,
   input wire logic                            io_update,
   input wire logic                            clk_mode_sel,
   input wire logic                            sync_clk,
   input wire logic                            single_bit_mode,
   input wire dssc_pkg::dssc_tone_t [NUM_CHAN-1:0] tone_out,
   input wire dssc_pkg::dssc_clk_cfg_t         clk_cfg
);
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // ****************************************
   // age of the last update request
   // ****************************************
   logic       upd_q;
   logic [4:0] upd_age;

   // previous pin level, for edge detection
   always_ff @(posedge core_clk) begin
      upd_q <= io_update;
   end

   // counts from the pin rise, saturates
   always_ff @(posedge core_clk) begin
      if (sys_rst)
         upd_age <= 5'h1f;
      else if (io_update && !upd_q)
         upd_age <= 5'h00;
      else if (upd_age != 5'h1f)
         upd_age <= upd_age + 5'h01;
   end

   // ****************************************
   // properties
   // ****************************************
   AST_SYNC_QUARTER: assert property ($rose(sync_clk) |=> sync_clk ##1 !sync_clk [*2] ##1 sync_clk)
      else $error("sync clock period wrong");
   AST_TONE_ON_UPDATE: assert property ($changed(tone_out) |-> upd_age < 5'h18)
      else $error("tone words changed without update");
   AST_RST_TONE: assert property (disable iff (1'b0) $fell(sys_rst) |-> tone_out == '0)
      else $error("tone words not cleared by reset");
   AST_RST_SINGLE: assert property (disable iff (1'b0) $fell(sys_rst) |-> single_bit_mode)
      else $error("single-bit mode not set by reset");
   AST_RST_VCO: assert property (disable iff (1'b0) $fell(sys_rst) |-> !clk_cfg.vco_high)
      else $error("vco range not low after reset");
   AST_RST_CP: assert property (disable iff (1'b0) $fell(sys_rst) |-> clk_cfg.cp_current == CP_75UA)
      else $error("charge pump not default after reset");
   AST_MULT_ON: assert property (clk_cfg.pll_enable |->
      clk_cfg.mult_factor >= MULT_MIN && clk_cfg.mult_factor <= MULT_MAX)
      else $error("multiplier on with bad factor");
   AST_MULT_OFF: assert property (!clk_cfg.pll_enable |-> clk_cfg.mult_factor == MULT_BYPASS)
      else $error("bypass factor not one");
   AST_XTAL_ON: assert property (clk_mode_sel [*6] |-> clk_cfg.xtal_osc_en && !clk_cfg.ref_buf_en)
      else $error("crystal oscillator not selected");
   AST_XTAL_OFF: assert property (!clk_mode_sel [*6] |-> clk_cfg.ref_buf_en && !clk_cfg.xtal_osc_en)
      else $error("reference buffer not selected");

   // main scenarios reached
   cover property ($changed(tone_out));
   cover property ($rose(clk_cfg.pll_enable));
   cover property ($rose(sdio_oe));
endmodule

bind dssc_top dssc_top_chk #(.NUM_CHAN(NUM_CHAN)) u_chk (
   .core_clk(core_clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
   .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
   .io_update(io_update), .clk_mode_sel(clk_mode_sel), .sync_clk(sync_clk),
   .single_bit_mode(single_bit_mode), .tone_out(tone_out), .clk_cfg(clk_cfg)
);

/* File: sim/dssc_host_model.sv */
// host side of the serial port, one register per frame
// assumes the bench calls xfer; pins change at falling core_clk edges
`timescale 1ns/1ns
module dssc_host_model (
   input  wire logic core_clk,
   input  wire logic sdio_out,
   input  wire logic sdio_oe,
   output logic      sclk,
   output logic      cs_n,
   output logic      sdio_in
);
   // idle pins, serial clock stands still low
   initial begin
      sclk    = 1'b0;
      cs_n    = 1'b1;
      sdio_in = 1'b0;
   end

   // instruction byte then nb data bytes, msb first
   task automatic xfer(input logic rd, input logic [4:0] a, input logic [31:0] d,
                       input int nb, output logic [31:0] q);
      logic [39:0] sh;
      int          i;
      sh = {rd, 2'b00, a, d << (32 - 8 * nb)};
      q  = '0;
      cs_n = 1'b0;
      for (i = 0; i < 8 + 8 * nb; i++) begin
         // released line toggles while the device answers
         sdio_in = (rd && i >= 8) ? ~sdio_in : sh[39-i];
         repeat (6) @(negedge core_clk);
         if (i >= 8)
            q = {q[30:0], sdio_out & sdio_oe};
         sclk = 1'b1;
         repeat (6) @(negedge core_clk);
         sclk = 1'b0;
      end
      repeat (6) @(negedge core_clk);
      cs_n    = 1'b1;
      sdio_in = ~sdio_in;
      repeat (6) @(negedge core_clk);
   endtask
endmodule

/* File: sim/dssc_top_bench.sv */
// self-checking bench of the single-tone and clock configuration block
// assumes dssc_pkg, dssc_top, the host model and the checker are compiled first
`timescale 1ns/1ns
module dssc_top_bench;
   import dssc_pkg::*;
   logic          core_clk     = 1'b0;
   logic          sys_rst      = 1'b1;
   logic          io_update    = 1'b0;
   logic          clk_mode_sel = 1'b0;
   logic          sclk, cs_n, sdio_in, sdio_out, sdio_oe, sync_clk, single_bit_mode, en;
   dssc_tone_t    [1:0] tone_out;
   dssc_clk_cfg_t clk_cfg;
   logic [31:0]   q;
   logic [4:0]    mv [6] = '{5'h00, 5'h03, 5'h04, 5'h0c, 5'h14, 5'h15};
   int            n_mismatch = 0, checked = 0, cyc = 0, i;

   dssc_top #(.NUM_CHAN(2)) i_dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
      .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .io_update(io_update), .clk_mode_sel(clk_mode_sel), .sync_clk(sync_clk),
      .single_bit_mode(single_bit_mode), .tone_out(tone_out), .clk_cfg(clk_cfg));

   dssc_host_model i_host (
      .core_clk(core_clk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in));

   // ****************************************
   // clock, timeout and helpers
   // ****************************************
   always #4 core_clk = ~core_clk;

   // cuts a hang short
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         results();
      end
   end

   task automatic chk(input logic [95:0] seen, input logic [95:0] exp, input string msg);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task automatic results;
      $display("checks %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d, input int nb);
      logic [31:0] unused;
      i_host.xfer(1'b0, a, d, nb, unused);
   endtask

   task automatic rd(input logic [4:0] a, input int nb);
      i_host.xfer(1'b1, a, 32'h0, nb, q);
   endtask

   // update pulse, then time for the words to land
   task automatic upd;
      io_update = 1'b1;
      repeat (10) @(negedge core_clk);
      io_update = 1'b0;
      repeat (24) @(negedge core_clk);
   endtask

   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      repeat (5) @(negedge core_clk);
      sys_rst = 1'b0;
      rd(ADDR_CHANNEL_SELECT, 1);
      chk(q, 32'hc0, "select reset");
      chk(single_bit_mode, 1'b1, "single-bit mode");
      chk(tone_out, '0, "tone reset");
      chk(clk_cfg, {1'b0, MULT_BYPASS, 1'b0, CP_75UA, 2'b01}, "clock reset");
      rd(ADDR_FUNCTION_CONFIG_ONE, 3);
      chk(q, CFG1_RST, "config reset");
      // core clock stands in for a crystal inside the allowed range
      clk_mode_sel = 1'b1;
      repeat (8) @(negedge core_clk);
      chk(clk_cfg.xtal_osc_en, 1'b1, "crystal on");
      clk_mode_sel = 1'b0;
      // one channel at a time, then a common update
      wr(ADDR_CHANNEL_SELECT, 32'h40, 1);
      wr(ADDR_FREQUENCY_TUNING, 32'h11111111, 4);
      wr(ADDR_PHASE_OFFSET, 32'h0aaa, 2);
      wr(ADDR_CHANNEL_SELECT, 32'h80, 1);
      rd(ADDR_FREQUENCY_TUNING, 4);
      chk(q, FREQ_RST, "enable acts at once");
      wr(ADDR_FREQUENCY_TUNING, 32'h22222222, 4);
      wr(ADDR_PHASE_OFFSET, 32'h0bbb, 2);
      chk(tone_out, '0, "held before update");
      upd();
      chk(tone_out, {32'h22222222, 16'h0bbb, 32'h11111111, 16'h0aaa}, "per channel");
      wr(ADDR_CHANNEL_SELECT, 32'hc0, 1);
      wr(ADDR_FREQUENCY_TUNING, 32'h33333333, 4);
      upd();
      chk(tone_out, {32'h33333333, 16'h0bbb, 32'h33333333, 16'h0aaa}, "both channels");
      // matched delay: frequency and phase land together
      wr(ADDR_CHANNEL_FUNCTION, 32'h20, 3);
      upd();
      wr(ADDR_FREQUENCY_TUNING, 32'h44444444, 4);
      wr(ADDR_PHASE_OFFSET, 32'h0ccc, 2);
      io_update = 1'b1;
      for (i = 0; i < 30 && tone_out[0] === {32'h33333333, 16'h0aaa}; i++)
         @(negedge core_clk);
      chk(tone_out[0], {32'h44444444, 16'h0ccc}, "matched step");
      io_update = 1'b0;
      repeat (24) @(negedge core_clk);
      // multiplier decode at and around the bounds
      for (i = 0; i < 6; i++) begin
         en = mv[i] >= MULT_MIN && mv[i] <= MULT_MAX;
         wr(ADDR_FUNCTION_CONFIG_ONE, {8'h00, mv[i] == 5'h0c, mv[i], 18'h0}, 3);
         upd();
         chk(clk_cfg, {en, en ? mv[i] : MULT_BYPASS, mv[i] == 5'h0c, CP_75UA, 2'b01}, "multiplier");
      end
      rd(5'h1f, 1);
      chk(q, 32'h0, "unmapped read");
      // reset in mid-run
      sys_rst = 1'b1;
      repeat (5) @(negedge core_clk);
      sys_rst = 1'b0;
      chk(tone_out, '0, "tone after reset");
      rd(ADDR_PHASE_OFFSET, 2);
      chk(q, PHASE_RST, "offset after reset");
      results();
   end
endmodule
